// ### operand_address_modes_defs.vh
// constants for the operand addressing-mode unit
`ifndef OPERAND_ADDRESS_MODES_DEFS_VH
`define OPERAND_ADDRESS_MODES_DEFS_VH
`define MODE_REGISTER 2'h0
`define MODE_INDEXED 2'h1
`define REG_PC 4'h0
`define REG_SR 4'h2
`define PC_STEP 16'h0002
`define PC_RESET 16'h0000
`define ST_IDLE 3'h0
`define ST_SRC_EXT 3'h1
`define ST_SRC_RD 3'h2
`define ST_DST_EXT 3'h3
`define ST_DST_RD 3'h4
`define ST_DONE 3'h5
`define ST_WB 3'h6
`endif

// ### operand_address_modes.v
// operand addressing-mode unit: register, indexed, symbolic, absolute
`timescale 1ns/1ns
`default_nettype none
`include "operand_address_modes_defs.vh"
module operand_address_modes #(
  parameter DW = 16
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // decoded instruction
  input wire start,
  input wire [1:0] source_mode_field,
  input wire [3:0] src_reg,
  input wire dst_mode,
  input wire [3:0] dst_reg,
  input wire byte_op,
  input wire [DW-1:0] pc_in,
  input wire pc_load,
  // register file read ports
  input wire [DW-1:0] src_reg_val,
  input wire [DW-1:0] dst_reg_val,
  // result from execution for write-back
  input wire [DW-1:0] result,
  input wire res_carry,
  // memory bus
  output reg mem_rd_q,
  output reg [DW-1:0] mem_addr_q,
  input wire [DW-1:0] mem_rdata,
  input wire mem_ack,
  // operands and addresses
  output reg [DW-1:0] src_op_q,
  output reg [DW-1:0] dst_op_q,
  output reg [DW-1:0] dst_addr_q,
  output reg dst_is_mem_q,
  output reg ops_valid_q,
  output reg [DW-1:0] pc_q,
  // register write-back and flags
  output reg wb_en_q,
  output reg [3:0] wb_reg_q,
  output reg [DW-1:0] wb_data_q,
  output reg flag_n_q,
  output reg flag_z_q,
  output reg flag_c_q
);

  // state codes; write-back sits one cycle after operands are offered
  localparam [2:0] S_IDLE = `ST_IDLE;
  localparam [2:0] S_SRC_EXT = `ST_SRC_EXT;
  localparam [2:0] S_SRC_RD = `ST_SRC_RD;
  localparam [2:0] S_DST_EXT = `ST_DST_EXT;
  localparam [2:0] S_DST_RD = `ST_DST_RD;
  localparam [2:0] S_DONE = `ST_DONE;
  localparam [2:0] S_WB = `ST_WB;

  reg [2:0] state_q;
  reg [DW-1:0] sbase_q;
  reg [DW-1:0] dbase_q;
  reg byte_q;
  reg [3:0] dreg_q;

  // other mode codes fall back to register mode; those forms live elsewhere
  wire src_ext = (source_mode_field == `MODE_INDEXED);

  // one adder serves both offsets; the state picks the base
  wire [DW-1:0] base_sel = (state_q == S_SRC_EXT) ? sbase_q : dbase_q;
  wire [DW-1:0] sum = mem_rdata + base_sel;

  // byte results keep only the low byte; N and Z follow that byte, C is taken from res_carry as given
  wire [DW-1:0] res_w = byte_q ? {{(DW-8){1'b0}}, result[7:0]} : result;
  wire res_neg = byte_q ? result[7] : result[DW-1];
  wire res_zero = byte_q ? (result[7:0] == 8'h00) : (result == {DW{1'b0}});

  // base for indexed forms; pc base is the extension word's own address
  function [DW-1:0] base_of;
    input [3:0] r;
    input [DW-1:0] val;
    input [DW-1:0] pc;
    begin
      if (r == `REG_PC)
        base_of = pc;
      else if (r == `REG_SR)
        base_of = {DW{1'b0}};
      else
        base_of = val;
    end
  endfunction

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      mem_rd_q <= 1'b0;
      mem_addr_q <= {DW{1'b0}};
      src_op_q <= {DW{1'b0}};
      dst_op_q <= {DW{1'b0}};
      dst_addr_q <= {DW{1'b0}};
      dst_is_mem_q <= 1'b0;
      ops_valid_q <= 1'b0;
      pc_q <= `PC_RESET;
      wb_en_q <= 1'b0;
      wb_reg_q <= 4'h0;
      wb_data_q <= {DW{1'b0}};
      flag_n_q <= 1'b0;
      flag_z_q <= 1'b0;
      flag_c_q <= 1'b0;
      sbase_q <= {DW{1'b0}};
      dbase_q <= {DW{1'b0}};
      byte_q <= 1'b0;
      dreg_q <= 4'h0;
    end else begin
      // strobes default low so each stands for exactly one cycle
      ops_valid_q <= 1'b0;
      wb_en_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // pc loads only while idle, so a stray load cannot skip extension words
          if (pc_load) begin
            pc_q <= pc_in;
          end
          if (start) begin
            byte_q <= byte_op;
            dreg_q <= dst_reg;
            dst_is_mem_q <= dst_mode;
            src_op_q <= src_reg_val;
            dst_op_q <= dst_reg_val;
            sbase_q <= base_of(src_reg, src_reg_val, pc_q);
            if (src_ext) begin
              // the source extension word always comes first
              state_q <= S_SRC_EXT;
              mem_rd_q <= 1'b1;
              mem_addr_q <= pc_q;
            end else if (dst_mode) begin
              state_q <= S_DST_EXT;
              mem_rd_q <= 1'b1;
              mem_addr_q <= pc_q;
              dbase_q <= base_of(dst_reg, dst_reg_val, pc_q);
            end else begin
              state_q <= S_DONE;
            end
          end
        end

        S_SRC_EXT: begin
          // address and request stand until the memory answers
          if (mem_ack) begin
            pc_q <= pc_q + `PC_STEP;
            mem_addr_q <= sum;
            state_q <= S_SRC_RD;
          end
        end

        S_SRC_RD: begin
          if (mem_ack) begin
            src_op_q <= mem_rdata;
            // pc is already past the source word: it addresses the destination word
            dbase_q <= base_of(dreg_q, dst_op_q, pc_q);
            if (dst_is_mem_q) begin
              mem_addr_q <= pc_q;
              state_q <= S_DST_EXT;
            end else begin
              mem_rd_q <= 1'b0;
              state_q <= S_DONE;
            end
          end
        end

        S_DST_EXT: begin
          if (mem_ack) begin
            pc_q <= pc_q + `PC_STEP;
            mem_addr_q <= sum;
            // the memory write itself is left to the caller; only the address is kept
            dst_addr_q <= sum;
            state_q <= S_DST_RD;
          end
        end

        S_DST_RD: begin
          if (mem_ack) begin
            dst_op_q <= mem_rdata;
            mem_rd_q <= 1'b0;
            state_q <= S_DONE;
          end
        end

        S_DONE: begin
          // operands offered for one cycle; result sampled at the end of that same cycle
          ops_valid_q <= 1'b1;
          state_q <= S_WB;
        end

        S_WB: begin
          // only the destination register is written; source stays intact
          wb_en_q <= ~dst_is_mem_q;
          wb_reg_q <= dreg_q;
          wb_data_q <= res_w;
          flag_n_q <= res_neg;
          flag_z_q <= res_zero;
          flag_c_q <= res_carry;
          state_q <= S_IDLE;
        end

        default: begin
          // unused codes recover to idle rather than hang the core
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // operand_address_modes
`default_nettype wire

// ### operand_address_modes_properties.sv
// checker for the operand addressing-mode unit
`timescale 1ns/1ns
`default_nettype none
module oam_chk(input wire logic ref_clk,rst_n,start,dst_mode,byte_op,ops_valid_q,mem_rd_q,
  mem_ack,wb_en_q,flag_z_q,dst_is_mem_q,input wire logic [1:0] source_mode_field,
  input wire logic [15:0] src_reg_val,src_op_q,mem_addr_q,pc_q,wb_data_q);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_src; start&&!source_mode_field&&!dst_mode|->##2 src_op_q==$past(src_reg_val,2);
  endproperty
  a_src: assert property (p_src) else $error("src");
  property p_nrd; start&&!source_mode_field&&!dst_mode|=>!mem_rd_q; endproperty
  a_nrd: assert property (p_nrd) else $error("nrd");
  property p_fst; start&&source_mode_field==2'h1|=>mem_rd_q&&mem_addr_q==$past(pc_q); endproperty
  a_fst: assert property (p_fst) else $error("fst");
  property p_hld; mem_rd_q&&!mem_ack|=>mem_rd_q&&$stable(mem_addr_q); endproperty
  a_hld: assert property (p_hld) else $error("hld");
  property p_pc; mem_ack&&mem_addr_q==pc_q|=>pc_q==$past(pc_q)+16'h0002; endproperty
  a_pc: assert property (p_pc) else $error("pc");
  property p_hi; wb_en_q&&byte_op|->wb_data_q[15:8]==8'h00; endproperty
  a_hi: assert property (p_hi) else $error("hi");
  property p_z; wb_en_q&&byte_op|->flag_z_q==(wb_data_q[7:0]==8'h00); endproperty
  a_z: assert property (p_z) else $error("z");
  property p_wb; ops_valid_q&&!dst_is_mem_q|=>!ops_valid_q##[0:1]wb_en_q; endproperty
  a_wb: assert property (p_wb) else $error("wb");
  c_wb: cover property (wb_en_q);
  c_mem: cover property (ops_valid_q&&dst_is_mem_q);
  c_slow: cover property ((mem_rd_q&&!mem_ack)[*2]);
endmodule // oam_chk
bind operand_address_modes oam_chk oam_chk_i(.ref_clk,.rst_n,.start,.dst_mode,.byte_op,
  .ops_valid_q,.mem_rd_q,.mem_ack,.wb_en_q,.flag_z_q,.dst_is_mem_q,.source_mode_field,
  .src_reg_val,.src_op_q,.mem_addr_q,.pc_q,.wb_data_q);
`default_nettype wire

// ### mem_model.sv
// word memory answering reads promptly or after two waits
`timescale 1ns/1ns
`default_nettype none
module mem_model #(parameter logic [15:0] K = 16'hA5C3) (input wire logic ref_clk,rst_n,
  mem_rd_q,slow,input wire logic [15:0] mem_addr_q,output logic mem_ack,
  output logic [15:0] mem_rdata);
  logic [1:0] w_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {mem_ack,w_q,mem_rdata} <= 19'h00000;
    end else if (mem_rd_q&&!mem_ack&&w_q>={slow,1'b0}) begin
      // word is the scrambled address, so the bench knows it
      {mem_ack,w_q,mem_rdata} <= {3'h4,mem_addr_q^K};
    end else begin
      // idle bus moves every cycle, never holds the old word
      {mem_ack,w_q,mem_rdata} <= {1'b0,(mem_rd_q&&!mem_ack)?w_q+2'h1:2'h0,~mem_rdata};
    end
  end
endmodule // mem_model
`default_nettype wire

// ### operand_address_modes_tb.sv
// bench for the operand addressing-mode unit
`timescale 1ns/1ns
`default_nettype none
module operand_address_modes_tb;
  localparam logic [15:0] K = 16'hA5C3;
  logic ref_clk=0,rst_n=0,start=0,dst_mode=0,byte_op=0,pc_load=0,slow=0,mem_rd_q,mem_ack;
  logic ops_valid_q,dst_is_mem_q,wb_en_q,flag_n_q,flag_z_q,flag_c_q,res_carry=0;
  logic [3:0] wb_reg_q;
  logic [15:0] dst_op_q;
  logic [1:0] source_mode_field=0;
  logic [3:0] src_reg=0,dst_reg=0;
  logic [15:0] pc_in=0,src_reg_val=0,dst_reg_val=0,result=0,mem_addr_q,mem_rdata,src_op_q;
  logic [15:0] dst_addr_q,pc_q,wb_data_q;
  int n_errors=0,comparisons=0,cyc=0;
  operand_address_modes operand_address_modes_i(.ref_clk,.rst_n,.start,.source_mode_field,
    .src_reg,.dst_mode,.dst_reg,.byte_op,.pc_in,.pc_load,.src_reg_val,.dst_reg_val,.result,
    .res_carry,.mem_rd_q,.mem_addr_q,.mem_rdata,.mem_ack,.src_op_q,.dst_op_q,
    .dst_addr_q,.dst_is_mem_q,.ops_valid_q,.pc_q,.wb_en_q,.wb_reg_q,.wb_data_q,.flag_n_q,
    .flag_z_q,.flag_c_q);
  mem_model #(.K(K)) mem_model_i(.ref_clk,.rst_n,.mem_rd_q,.slow,.mem_addr_q,.mem_ack,.mem_rdata);
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      complete_run();
    end
  end
  task complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task go(input logic [1:0] m, input logic [3:0] sr, input logic dm,
    input logic [3:0] dr, input logic [15:0] sv, dv, pc);
    @(negedge ref_clk);
    {source_mode_field,src_reg,dst_mode,dst_reg,src_reg_val,dst_reg_val,pc_in} = {m,sr,dm,dr,sv,dv,pc};
    pc_load = 1;
    @(negedge ref_clk);
    {pc_load,start} = 2'h1;
    @(negedge ref_clk);
    start = 0;
    while (ops_valid_q !== 1'b1) @(negedge ref_clk);
  endtask
  task t_reg();
    {byte_op,res_carry,result} = {2'h3,16'h7F80};
    go(2'h0, 4'hA, 1'b0, 4'hB, 16'hA023, 16'hFA15, 16'h0100);
    chk(src_op_q, 16'hA023);
    chk(pc_q, 16'h0100);
    repeat (3) if (wb_en_q !== 1'b1) @(negedge ref_clk);
    chk(wb_data_q, 16'h0080);
    chk(flag_n_q, 16'h0001);
    chk(wb_reg_q, 16'h000B);
    chk(flag_z_q, 16'h0000);
    chk(flag_c_q, 16'h0001);
  endtask
  task t_mix();
    {byte_op,res_carry,result,slow} = {2'h3,16'hFF00,1'b0};
    go(2'h0, 4'h5, 1'b1, 4'h6, 16'h1202, 16'h0200, 16'h0300);
    chk(src_op_q, 16'h1202);
    chk(dst_addr_q, 16'h0200+(16'h0300^K));
    chk(dst_op_q, (16'h0200+(16'h0300^K))^K);
    chk(pc_q, 16'h0302);
    go(2'h1, 4'h5, 1'b0, 4'h7, 16'h1080, 16'h00FF, 16'h0400);
    chk(src_op_q, (16'h1080+(16'h0400^K))^K);
    chk(pc_q, 16'h0402);
    repeat (3) if (wb_en_q !== 1'b1) @(negedge ref_clk);
    chk(wb_en_q, 16'h0001);
    chk(wb_reg_q, 16'h0007);
    chk(wb_data_q, 16'h0000);
    chk({flag_n_q,flag_z_q,flag_c_q}, 16'h0003);
  endtask
  task t_sym();
    {byte_op,slow} = 2'h1;
    go(2'h1, 4'h0, 1'b1, 4'h6, 16'h1111, 16'h108C, 16'hFF14);
    chk(src_op_q, (16'hFF14+(16'hFF14^K))^K);
    chk(dst_addr_q, 16'h108C+(16'hFF16^K));
    chk(dst_op_q, (16'h108C+(16'hFF16^K))^K);
    chk(pc_q, 16'hFF18);
  endtask
  task t_abs();
    slow = 0;
    go(2'h1, 4'h2, 1'b1, 4'h2, 16'h1234, 16'h5678, 16'hF016);
    chk(src_op_q, (16'hF016^K)^K);
    chk(dst_addr_q, 16'hF018^K);
    chk(pc_q, 16'hF01A);
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1;
    t_reg();
    t_sym();
    t_abs();
    t_mix();
    complete_run();
  end
endmodule // operand_address_modes_tb
`default_nettype wire
